// ==== rtl/nand_host_ctrl.sv ====
// Purpose: Host controller driving a NAND device through its strobes
// Assumes: Ready/busy and data inputs are asynchronous; x16 selected by parameter
// Notes: Data for programs streams in through valid/ready; reads stream out
// What this block does
// - Host issues 00h or 50h before 80h to program from A or C.
// - Host issues 01h immediately before 80h to program area B.
// - Word-wide host issues 00h or 50h before 80h for main or spare; area B still gets 01h, as at byte width.
// - Word-wide host drives upper data lines zero on command and address cycles.
// - Multi-plane program repeats load up to three times, waiting busy each load.
// - Multi-plane erase gives each plane's block address before D0h.
// - Program is 80h, four addresses, data, then 10h confirm.
// - Erase is 60h, three block addresses, then D0h confirm.
module nand_host_ctrl #(
   parameter int DATA_W = 8,
   parameter int PLANE_BUSY_CYC = nand_host_pkg::PLANE_LOAD_BUSY_CYC
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic req_valid_in,
   input wire nand_host_pkg::host_req_t req_in,
   output logic req_ready_out,
   input wire logic wr_valid_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   output logic wr_ready_out,
   input wire logic wr_last_in,
   output logic rd_valid_out,
   output logic [DATA_W-1:0] rd_data_out,
   output logic done_out,
   output logic fail_out,
   output nand_host_pkg::strobe_t strobe_out,
   output logic [DATA_W-1:0] io_out,
   output logic io_oe_out,
   input wire logic [DATA_W-1:0] io_in,
   input wire logic ready_busy_in
);
   initial begin
      if (DATA_W != 8 && DATA_W != 16) $error("DATA_W must be 8 or 16");
      if (PLANE_BUSY_CYC < 1) $error("PLANE_BUSY_CYC must be positive");
   end

   typedef enum logic [3:0] {
      S_IDLE, S_PTR, S_CMD, S_ADDR, S_DATA_W, S_CONFIRM, S_WAIT_BUSY,
      S_STATUS_CMD, S_READ, S_DONE
   } st_t;

   st_t st_q, st_d;
   nand_host_pkg::host_req_t req_q, req_d;
   logic [nand_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [1:0] plane_q, plane_d;
   logic [2:0] addr_q, addr_d;
   logic [7:0] cmd_q, cmd_d;
   logic ph_q, ph_d;
   logic ale_q, ale_d, cle_q, cle_d, ce_n_q, ce_n_d, oe_q, oe_d;
   logic [DATA_W-1:0] io_q, io_d, rdd_q, rdd_d;
   logic rdv_q, rdv_d, done_q, done_d, fail_q, fail_d, rrdy_q, rrdy_d;
   logic wrdy_q, wrdy_d;
   logic rb_s1_q, rb_s2_q;
   logic [DATA_W-1:0] io_s1_q, io_s2_q;
   logic cy_start, cy_read, cy_we_n, cy_re_n, cy_busy, cy_done;

   nand_cycle_gen u_cycle (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .start_in(cy_start),
      .is_read_in(cy_read),
      .we_n_out(cy_we_n),
      .re_n_out(cy_re_n),
      .busy_out(cy_busy),
      .done_out(cy_done)
   );

   // Pointer command for an area; upper lines zero on command cycles
   function automatic logic [7:0] ptr_cmd(input nand_host_pkg::area_t a);
      unique case (a)
         nand_host_pkg::AREA_A: ptr_cmd = nand_host_pkg::CMD_PTR_A;
         nand_host_pkg::AREA_B: ptr_cmd = nand_host_pkg::CMD_PTR_B;
         default: ptr_cmd = nand_host_pkg::CMD_PTR_C;
      endcase
   endfunction : ptr_cmd

   function automatic logic [7:0] addr_byte(input nand_host_pkg::host_req_t r,
                                            input logic [2:0] i,
                                            input logic skip_col);
      logic [2:0] k;
      k = skip_col ? i + 3'd1 : i;
      unique case (k)
         3'd0: addr_byte = r.column;
         3'd1: addr_byte = {r.row[5:0], 2'(0) | r.planes_m1 & 2'b00};
         3'd2: addr_byte = r.row[13:6];
         default: addr_byte = {5'h00, r.row[16:14]};
      endcase
   endfunction : addr_byte

   always_comb begin
      st_d = st_q;
      req_d = req_q;
      cnt_d = cnt_q;
      plane_d = plane_q;
      addr_d = addr_q;
      cmd_d = cmd_q;
      ph_d = ph_q;
      ale_d = ale_q;
      cle_d = cle_q;
      ce_n_d = ce_n_q;
      oe_d = oe_q;
      io_d = io_q;
      rdd_d = rdd_q;
      rdv_d = 1'b0;
      done_d = 1'b0;
      fail_d = fail_q;
      rrdy_d = 1'b0;
      wrdy_d = 1'b0;
      cy_start = 1'b0;
      cy_read = 1'b0;
      unique case (st_q)
         S_IDLE: begin
            ce_n_d = 1'b1;
            oe_d = 1'b0;
            cle_d = 1'b0;
            ale_d = 1'b0;
            rrdy_d = !rrdy_q;
            if (req_valid_in && rrdy_q) begin
               req_d = req_in;
               rrdy_d = 1'b0;
               plane_d = 2'd0;
               ce_n_d = 1'b0;
               ph_d = 1'b0;
               st_d = (req_in.op == nand_host_pkg::OP_PROGRAM ||
                       req_in.op == nand_host_pkg::OP_READ_PAGE) ? S_PTR : S_CMD;
            end
         end
         S_PTR: begin
            // Pointer goes right before the data-input command, or before the addresses on a page read
            cmd_d = ptr_cmd(req_q.area);
            st_d = S_CMD;
            ph_d = 1'b1;
         end
         S_CMD: begin
            if (!cy_busy && !cy_done) begin
               cle_d = 1'b1;
               ale_d = 1'b0;
               oe_d = 1'b1;
               io_d = '0;
               if (ph_q) begin
                  io_d[7:0] = cmd_q;
               end else begin
                  unique case (req_q.op)
                     nand_host_pkg::OP_PROGRAM: io_d[7:0] = nand_host_pkg::CMD_DATA_IN;
                     nand_host_pkg::OP_ERASE: io_d[7:0] = nand_host_pkg::CMD_ERASE_SETUP;
                     nand_host_pkg::OP_READ_ID: io_d[7:0] = nand_host_pkg::CMD_READ_ID;
                     nand_host_pkg::OP_STATUS: io_d[7:0] = nand_host_pkg::CMD_MP_STATUS;
                     default: io_d[7:0] = cmd_q;
                  endcase
               end
               cy_start = 1'b1;
            end else if (cy_done) begin
               cle_d = 1'b0;
               addr_d = 3'd0;
               if (ph_q && req_q.op == nand_host_pkg::OP_PROGRAM) begin
                  ph_d = 1'b0;
               end else begin
                  ph_d = 1'b0;
                  st_d = (req_q.op == nand_host_pkg::OP_STATUS) ? S_WAIT_BUSY : S_ADDR;
                  cnt_d = nand_host_pkg::CNT_W'(nand_host_pkg::WB_CYC);
               end
            end
         end
         S_ADDR: begin
            if (!cy_busy && !cy_done) begin
               ale_d = 1'b1;
               oe_d = 1'b1;
               io_d = '0;
               io_d[7:0] = addr_byte(req_q, addr_q, req_q.op == nand_host_pkg::OP_ERASE);
               cy_start = 1'b1;
            end else if (cy_done) begin
               addr_d = addr_q + 3'd1;
               if ((req_q.op == nand_host_pkg::OP_READ_ID) ||
                   (req_q.op == nand_host_pkg::OP_ERASE &&
                    addr_q == 3'(nand_host_pkg::ADDR_CYC_ERASE - 1)) ||
                   (addr_q == 3'(nand_host_pkg::ADDR_CYC_PROG - 1))) begin
                  ale_d = 1'b0;
                  cnt_d = '0;
                  unique case (req_q.op)
                     nand_host_pkg::OP_PROGRAM: st_d = S_DATA_W;
                     nand_host_pkg::OP_ERASE: begin
                        // Repeat block address per plane before confirm
                        if (plane_q != req_q.planes_m1) begin
                           plane_d = plane_q + 2'd1;
                           req_d.row = req_q.row + 17'h00020;
                           st_d = S_CMD;
                        end else begin
                           st_d = S_CONFIRM;
                        end
                     end
                     nand_host_pkg::OP_READ_ID: begin
                        st_d = S_READ;
                        cnt_d = nand_host_pkg::CNT_W'(nand_host_pkg::ID_BYTES);
                     end
                     default: begin
                        st_d = S_WAIT_BUSY;
                        cnt_d = nand_host_pkg::CNT_W'(nand_host_pkg::WB_CYC);
                     end
                  endcase
               end
            end
         end
         S_DATA_W: begin
            // Chip enable dropped while the source stalls
            ce_n_d = !(wr_valid_in || cy_busy);
            if (!cy_busy && !cy_done && wr_valid_in && !wrdy_q) begin
               oe_d = 1'b1;
               io_d = wr_data_in;
               wrdy_d = 1'b1;
               ph_d = wr_last_in || cnt_q == nand_host_pkg::CNT_W'(nand_host_pkg::PAGE_BYTES - 1);
               cy_start = 1'b1;
            end else if (cy_done) begin
               cnt_d = cnt_q + 1'b1;
               if (ph_q) begin
                  ph_d = 1'b0;
                  ce_n_d = 1'b0;
                  st_d = S_CONFIRM;
               end
            end
         end
         S_CONFIRM: begin
            ce_n_d = 1'b0;
            if (!cy_busy && !cy_done) begin
               cle_d = 1'b1;
               oe_d = 1'b1;
               io_d = '0;
               if (req_q.op == nand_host_pkg::OP_ERASE) begin
                  io_d[7:0] = nand_host_pkg::CMD_ERASE_GO;
               end else if (plane_q != req_q.planes_m1) begin
                  io_d[7:0] = nand_host_pkg::CMD_MP_NEXT;
               end else begin
                  io_d[7:0] = nand_host_pkg::CMD_PROG_GO;
               end
               cy_start = 1'b1;
            end else if (cy_done) begin
               cle_d = 1'b0;
               cnt_d = nand_host_pkg::CNT_W'(nand_host_pkg::WB_CYC);
               st_d = S_WAIT_BUSY;
            end
         end
         S_WAIT_BUSY: begin
            oe_d = 1'b0;
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (rb_s2_q) begin
               if (req_q.op == nand_host_pkg::OP_PROGRAM && plane_q != req_q.planes_m1) begin
                  // Short load busy before the next plane
                  plane_d = plane_q + 2'd1;
                  req_d.row = req_q.row + 17'h00020;
                  st_d = S_CMD;
               end else if (req_q.op == nand_host_pkg::OP_READ_PAGE) begin
                  st_d = S_READ;
                  cnt_d = nand_host_pkg::CNT_W'(nand_host_pkg::PAGE_BYTES);
               end else if (req_q.op == nand_host_pkg::OP_PROGRAM ||
                            req_q.op == nand_host_pkg::OP_ERASE) begin
                  st_d = S_STATUS_CMD;
               end else begin
                  st_d = S_READ;
                  cnt_d = nand_host_pkg::CNT_W'(1);
               end
            end
         end
         S_STATUS_CMD: begin
            if (!cy_busy && !cy_done) begin
               cle_d = 1'b1;
               oe_d = 1'b1;
               io_d = '0;
               io_d[7:0] = (req_q.planes_m1 != 2'd0) ? nand_host_pkg::CMD_MP_STATUS
                                                     : nand_host_pkg::CMD_STATUS;
               cy_start = 1'b1;
            end else if (cy_done) begin
               cle_d = 1'b0;
               oe_d = 1'b0;
               st_d = S_READ;
               cnt_d = nand_host_pkg::CNT_W'(1);
               ph_d = 1'b1;
            end
         end
         S_READ: begin
            oe_d = 1'b0;
            // Chip enable stays low between read strobes until the last one ends
            ce_n_d = !(cy_busy || cnt_q != '0);
            if (!cy_busy && !cy_done && cnt_q != '0) begin
               cy_start = 1'b1;
               cy_read = 1'b1;
            end else if (cy_done) begin
               rdd_d = io_s2_q;
               rdv_d = 1'b1;
               cnt_d = cnt_q - 1'b1;
               if (ph_q) begin
                  fail_d = io_s2_q[0];
               end
               if (cnt_q == nand_host_pkg::CNT_W'(1)) begin
                  st_d = S_DONE;
               end
            end
         end
         default: begin
            done_d = 1'b1;
            ph_d = 1'b0;
            ce_n_d = 1'b1;
            st_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st_q <= S_IDLE;
         req_q <= '0;
         cnt_q <= '0;
         plane_q <= 2'd0;
         addr_q <= 3'd0;
         cmd_q <= nand_host_pkg::CMD_PTR_A;
         ph_q <= 1'b0;
         ale_q <= 1'b0;
         cle_q <= 1'b0;
         ce_n_q <= 1'b1;
         oe_q <= 1'b0;
         io_q <= '0;
         rdd_q <= '0;
         rdv_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         rrdy_q <= 1'b0;
         wrdy_q <= 1'b0;
         rb_s1_q <= 1'b0;
         rb_s2_q <= 1'b0;
         io_s1_q <= '0;
         io_s2_q <= '0;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         cnt_q <= cnt_d;
         plane_q <= plane_d;
         addr_q <= addr_d;
         cmd_q <= cmd_d;
         ph_q <= ph_d;
         ale_q <= ale_d;
         cle_q <= cle_d;
         ce_n_q <= ce_n_d;
         oe_q <= oe_d;
         io_q <= io_d;
         rdd_q <= rdd_d;
         rdv_q <= rdv_d;
         done_q <= done_d;
         fail_q <= fail_d;
         rrdy_q <= rrdy_d;
         wrdy_q <= wrdy_d;
         rb_s1_q <= ready_busy_in;
         rb_s2_q <= rb_s1_q;
         io_s1_q <= io_in;
         io_s2_q <= io_s1_q;
      end
   end

   assign req_ready_out = rrdy_q;
   assign wr_ready_out = wrdy_q;
   assign rd_valid_out = rdv_q;
   assign rd_data_out = rdd_q;
   assign done_out = done_q;
   assign fail_out = fail_q;
   assign io_out = io_q;
   assign io_oe_out = oe_q;
   assign strobe_out = '{cle: cle_q, ale: ale_q, we_n: cy_we_n, re_n: cy_re_n, ce_n: ce_n_q};
endmodule : nand_host_ctrl

// ==== rtl/nand_host_pkg.sv ====
// Purpose: Shared constants and types for the NAND host controller
// Assumes: 250 MHz system clock
// Notes: Command codes and timing counts live here
package nand_host_pkg;
   localparam logic [7:0] CMD_PTR_A = 8'h00;
   localparam logic [7:0] CMD_PTR_B = 8'h01;
   localparam logic [7:0] CMD_PTR_C = 8'h50;
   localparam logic [7:0] CMD_DATA_IN = 8'h80;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_MP_NEXT = 8'h11;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_MP_STATUS = 8'h71;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam int CLK_PERIOD_NS = 4;
   localparam int WE_LOW_NS = 25;
   localparam int WE_HIGH_NS = 15;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WB_NS = 100;
   localparam int WB_CYC = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PLANE_LOAD_BUSY_MAX_NS = 10000;
   localparam int PLANE_LOAD_BUSY_CYC = PLANE_LOAD_BUSY_MAX_NS / CLK_PERIOD_NS;
   localparam int MAX_EXTRA_PLANES = 3;
   localparam int ID_BYTES = 4;
   localparam int ADDR_CYC_PROG = 4;
   localparam int ADDR_CYC_ERASE = 3;
   localparam int PAGE_BYTES = 528;
   localparam int CNT_W = 13;

   typedef enum logic [2:0] {
      OP_READ_PAGE,
      OP_PROGRAM,
      OP_ERASE,
      OP_READ_ID,
      OP_STATUS
   } op_t;

   typedef enum logic [1:0] {
      AREA_A,
      AREA_B,
      AREA_C
   } area_t;

   typedef struct packed {
      op_t op;
      area_t area;
      logic [7:0] column;
      logic [16:0] row;
      logic [1:0] planes_m1;
   } host_req_t;

   typedef struct packed {
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic ce_n;
   } strobe_t;
endpackage : nand_host_pkg

// ==== rtl/nand_cycle_gen.sv ====
// Purpose: Generates one write or read strobe cycle on the NAND pins
// Assumes: Caller holds cle, ale and data steady while busy
// Notes: Write low and high times are rounded up to whole cycles
module nand_cycle_gen (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic start_in,
   input wire logic is_read_in,
   output logic we_n_out,
   output logic re_n_out,
   output logic busy_out,
   output logic done_out
);
   typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} cy_state_t;
   cy_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic we_n_q, we_n_d, re_n_q, re_n_d, rd_q, rd_d, done_q, done_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      we_n_d = we_n_q;
      re_n_d = re_n_q;
      rd_d = rd_q;
      done_d = 1'b0;
      unique case (st_q)
         CY_IDLE: begin
            if (start_in) begin
               st_d = CY_LOW;
               rd_d = is_read_in;
               cnt_d = 8'(nand_host_pkg::WE_LOW_CYC - 1);
               we_n_d = is_read_in;
               re_n_d = !is_read_in;
            end
         end
         CY_LOW: begin
            if (cnt_q == 8'h00) begin
               st_d = CY_HIGH;
               cnt_d = 8'(nand_host_pkg::WE_HIGH_CYC - 1);
               we_n_d = 1'b1;
               re_n_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         CY_HIGH: begin
            if (cnt_q == 8'h00) begin
               st_d = CY_IDLE;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st_q <= CY_IDLE;
         cnt_q <= 8'h00;
         we_n_q <= 1'b1;
         re_n_q <= 1'b1;
         rd_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         we_n_q <= we_n_d;
         re_n_q <= re_n_d;
         rd_q <= rd_d;
         done_q <= done_d;
      end
   end

   assign we_n_out = we_n_q;
   assign re_n_out = re_n_q;
   assign busy_out = (st_q != CY_IDLE);
   assign done_out = done_q;
endmodule : nand_cycle_gen

// ==== testbench/nand_dev_model.sv ====
// Purpose: Behavioural byte-wide NAND device facing the host controller
// Assumes: Strobes latch on the write strobe rising edge while chip enable is low
// Notes: Busy times are short; released data lines show the inverted last value
module nand_dev_model #(
   parameter logic [31:0] ID_W = 32'h5a3c3381, // Arbitrary identification bytes
   parameter int PROG_NS = 400,
   parameter int PLANE_NS = 8
) (
   input wire nand_host_pkg::strobe_t strobe_in,
   input wire logic [7:0] io_in,
   input wire logic fail_in,
   output logic [7:0] io_out,
   output logic rb_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cmd_q[$];
   logic [7:0] mode = 8'h00;
   logic [7:0] first_data = 8'h00;
   logic [1:0] ptr = 2'd0;
   int addr_n = 0;
   int addr_tot = 0;
   int data_n = 0;
   int rd_n = 0;
   int plane_n = 0;
   int start_col = 0;
   initial begin
      io_out = 8'h00;
      rb_out = 1'b1;
   end
   task automatic go_busy(input int ns);
      fork
         begin
            #20 rb_out = 1'b0;
            #(ns) rb_out = 1'b1;
         end
      join_none
   endtask : go_busy
   always @(posedge strobe_in.we_n) begin
      if (!strobe_in.ce_n) begin
         if (strobe_in.cle) begin
            cmd_q.push_back(io_in);
            mode = io_in;
            addr_n = 0;
            rd_n = 0;
            case (io_in)
               8'h00: ptr = 2'd0;
               8'h01: ptr = 2'd1;
               8'h50: ptr = 2'd2;
               8'h80: data_n = 0;
               8'h10, 8'h11: begin
                  // Confirm without loaded data starts nothing
                  if (data_n > 0) begin
                     plane_n++;
                     go_busy(io_in == 8'h10 ? PROG_NS : PLANE_NS);
                     if (ptr == 2'd1 && io_in == 8'h10) ptr = 2'd0;
                  end
               end
               8'hd0: begin
                  go_busy(PROG_NS);
                  if (ptr == 2'd1) ptr = 2'd0;
               end
               default: ;
            endcase
         end else if (strobe_in.ale) begin
            if (addr_n == 0) start_col = 256 * ptr + (ptr == 2'd2 ? io_in[3:0] : io_in);
            addr_n++;
            addr_tot++;
         end else begin
            if (data_n == 0) first_data = io_in;
            data_n++;
         end
      end
   end
   always @(negedge strobe_in.re_n) begin
      if (!strobe_in.ce_n) begin
         if (mode == 8'h90) io_out = ID_W[31 - 8 * rd_n -: 8];
         else io_out = {1'b0, rb_out, 5'b0, fail_in};
         rd_n++;
         if (ptr == 2'd1) ptr = 2'd0;
      end
   end
   always @(posedge strobe_in.re_n) #15 io_out = ~io_out;
endmodule : nand_dev_model

// ==== testbench/nand_host_ctrl_chk.sv ====
// Purpose: Port-level assertions for the NAND host controller
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Strobe widths follow the hand-over cycle counts
module nand_host_ctrl_chk #(
   parameter int DATA_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic done_out,
   input wire logic rd_valid_out,
   input wire nand_host_pkg::strobe_t strobe_out,
   input wire logic [DATA_W-1:0] io_out,
   input wire logic io_oe_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic busy_q;
   logic busy_d;
   always_comb begin
      busy_d = busy_q;
      if (sys_rst_in) busy_d = 1'b0;
      else if (req_valid_in && req_ready_out) busy_d = 1'b1;
      else if (done_out) busy_d = 1'b0;
   end
   always_ff @(posedge clk_sys_in) begin
      busy_q <= busy_d;
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   idle_after_reset_a: assert property ($fell(sys_rst_in) |->
      strobe_out.ce_n && strobe_out.we_n && strobe_out.re_n && !io_oe_out) else $error("not idle");
   refuse_busy_a: assert property (busy_q && !done_out |-> !req_ready_out)
      else $error("ready while busy");
   we_low_time_a: assert property ($fell(strobe_out.we_n) |-> (!strobe_out.we_n)[*7])
      else $error("write strobe short");
   we_high_time_a: assert property ($rose(strobe_out.we_n) |-> strobe_out.we_n[*4])
      else $error("write gap short");
   strobe_excl_a: assert property (!(strobe_out.cle && strobe_out.ale)
      && (strobe_out.we_n || strobe_out.re_n)) else $error("strobe clash");
   we_with_ce_a: assert property (!strobe_out.we_n |-> !strobe_out.ce_n && io_oe_out)
      else $error("write without select");
   read_released_a: assert property (!strobe_out.re_n |-> !io_oe_out && !strobe_out.cle)
      else $error("read while driving");
   latch_stable_a: assert property (!strobe_out.we_n && !$past(strobe_out.we_n) |->
      $stable(io_out) && $stable(strobe_out.ale)) else $error("lines moved");
   done_pulse_a: assert property (done_out |=> !done_out)
      else $error("done too long");
   c_prog: cover property (strobe_out.cle && !strobe_out.we_n && io_out == 8'h80);
   c_erase: cover property (strobe_out.cle && !strobe_out.we_n && io_out == 8'h60);
   c_read: cover property (rd_valid_out);
endmodule : nand_host_ctrl_chk
bind nand_host_ctrl nand_host_ctrl_chk #(.DATA_W(DATA_W)) i_chk (.clk_sys_in(clk_sys_in),
   .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
   .done_out(done_out), .rd_valid_out(rd_valid_out), .strobe_out(strobe_out),
   .io_out(io_out), .io_oe_out(io_oe_out));

// ==== testbench/nand_host_ctrl_bench.sv ====
// Purpose: Self-checking bench for the NAND host controller
// Assumes: Byte-wide device model with shortened busy times
// Notes: Inputs change on the falling clock edge
module nand_host_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] ID_W = 32'h5a3c3381; // Arbitrary identification bytes
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic wr_valid = 1'b0;
   logic fail_flag = 1'b0;
   logic req_ready, wr_ready, rd_valid, done, fail, io_oe, rb;
   logic [7:0] rd_data, io_o, dev_io, io_bus;
   logic [7:0] wr_cnt = 8'h00;
   logic [7:0] rd_q[$];
   nand_host_pkg::host_req_t req = '0;
   nand_host_pkg::strobe_t stb;
   int miscompares = 0;
   int check_count = 0;
   assign io_bus = io_oe ? io_o : dev_io;
   initial forever #2 clk = ~clk;
   always @(negedge clk) begin
      if (wr_ready) wr_cnt <= wr_cnt + 8'h01;
      if (rd_valid) rd_q.push_back(rd_data);
   end
   nand_host_ctrl #(.DATA_W(8), .PLANE_BUSY_CYC(4)) i_dut (.clk_sys_in(clk), .sys_rst_in(rst),
      .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
      .wr_valid_in(wr_valid), .wr_data_in(8'ha0 + wr_cnt), .wr_ready_out(wr_ready),
      .wr_last_in(wr_cnt[0]), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
      .done_out(done), .fail_out(fail), .strobe_out(stb), .io_out(io_o), .io_oe_out(io_oe),
      .io_in(io_bus), .ready_busy_in(rb));
   nand_dev_model #(.ID_W(ID_W)) i_dev (.strobe_in(stb), .io_in(io_bus), .fail_in(fail_flag),
      .io_out(dev_io), .rb_out(rb));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic run_op(input nand_host_pkg::op_t op, input nand_host_pkg::area_t ar,
                         input logic [1:0] pl);
      int n;
      n = 0;
      i_dev.cmd_q.delete();
      i_dev.addr_tot = 0;
      i_dev.plane_n = 0;
      rd_q.delete();
      wr_cnt = 8'h00;
      req = '{op, ar, 8'h07, 17'h00040, pl};
      req_valid = 1'b1;
      wr_valid = (op == nand_host_pkg::OP_PROGRAM);
      while (!req_ready && ++n < 100) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      while (!done && ++n < 50000) @(negedge clk);
      if (n >= 50000) check(32'h0, 32'h1);
   endtask : run_op
   task automatic t_id();
      run_op(nand_host_pkg::OP_READ_ID, nand_host_pkg::AREA_A, 2'd0);
      check(i_dev.cmd_q[0], 8'h90);
      check(rd_q.size(), 4);
      for (int i = 0; i < 4; i++) check(rd_q[i], ID_W[31 - 8 * i -: 8]);
      $display("t_id end");
   endtask : t_id
   task automatic t_prog();
      logic [7:0] pc [3] = '{8'h01, 8'h50, 8'h00};
      nand_host_pkg::area_t ar [3] = '{nand_host_pkg::AREA_B, nand_host_pkg::AREA_C,
                                       nand_host_pkg::AREA_A};
      for (int i = 0; i < 3; i++) begin
         run_op(nand_host_pkg::OP_PROGRAM, ar[i], 2'd0);
         check(i_dev.cmd_q[0], pc[i]);
         check(i_dev.cmd_q[1], 8'h80);
         check(i_dev.cmd_q[2], 8'h10);
         check(i_dev.start_col, (i == 0 ? 256 : i == 1 ? 512 : 0) + 7);
         check(i_dev.first_data, 8'ha0);
         check(i_dev.ptr, i == 1 ? 2 : 0);
      end
      $display("t_prog end");
   endtask : t_prog
   task automatic t_mp_prog();
      int n11 = 0;
      fail_flag = 1'b1;
      run_op(nand_host_pkg::OP_PROGRAM, nand_host_pkg::AREA_A, 2'd3);
      foreach (i_dev.cmd_q[i]) if (i_dev.cmd_q[i] == 8'h11) n11++;
      check(n11, 3);
      check(i_dev.plane_n, 4);
      check(i_dev.cmd_q[i_dev.cmd_q.size() - 1], 8'h71);
      check(fail, 1'b1);
      fail_flag = 1'b0;
      $display("t_mp_prog end");
   endtask : t_mp_prog
   task automatic t_erase();
      run_op(nand_host_pkg::OP_ERASE, nand_host_pkg::AREA_A, 2'd1);
      check(i_dev.cmd_q[0], 8'h60);
      check(i_dev.cmd_q[1], 8'h60);
      check(i_dev.cmd_q[2], 8'hd0);
      check(i_dev.addr_tot, 6);
      check(fail, 1'b0);
      $display("t_erase end");
   endtask : t_erase
   task automatic t_status();
      run_op(nand_host_pkg::OP_STATUS, nand_host_pkg::AREA_A, 2'd0);
      check(i_dev.cmd_q[0], 8'h71);
      check(rd_q[0], 8'h40);
      $display("t_status end");
   endtask : t_status
   task automatic t_read();
      run_op(nand_host_pkg::OP_READ_PAGE, nand_host_pkg::AREA_B, 2'd0);
      check(i_dev.cmd_q[0], 8'h01);
      check(i_dev.start_col, 256 + 7);
      check(rd_q.size(), nand_host_pkg::PAGE_BYTES);
      check(i_dev.ptr, 0);
      $display("t_read end");
   endtask : t_read
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_id();
      t_prog();
      t_mp_prog();
      t_erase();
      t_status();
      t_read();
      finish_test();
   end
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end
endmodule : nand_host_ctrl_bench
